// *** rtl/bss_boot_select.sv ***
// Functional notes
// - at boot choose flash execution or loader from pins or definitions
// - default pins both high branch to flash entry 0x0008_0000
// - pin selection and validity key come from word at 0xD00
// - boot definition entries come from the word at 0xD04
// - key 0x5A with all pin fields ones disables pins, zero-pin boot
// - zero-pin boot uses only the lowest definition entry
// - option 0x63 starts execution at 0x0009_0000
// - emulation words use the same layout as otp words
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module bss_boot_select
    import bss_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // boot select pins, asynchronous
    input  wire logic        bootSelectPinA,
    input  wire logic        bootSelectPinB,
    // software register port
    input  wire logic [11:0] regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic [31:0]      regRdata,
    // boot decision
    output logic             bootDone,
    output bss_src_t         bootSource,
    output logic [31:0]      bootEntry
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [1:0] syncA;
    logic [1:0] syncB;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncA <= 2'h0;
            syncB <= 2'h0;
        end else begin
            syncA <= {syncA[0], bootSelectPinA};
            syncB <= {syncB[0], bootSelectPinB};
        end
    end

    // ****************************************
    // registers
    // ****************************************
    logic [31:0] pinConfig;
    logic [31:0] bootDefLow;
    logic        rebootReq;
    bss_result_t result;
    logic        keyValid;
    logic        zeroPin;
    bss_src_t    next_source;
    logic [7:0]  next_option;
    logic [31:0] next_entry;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinConfig  <= RESET_WORD;
            bootDefLow <= RESET_WORD;
        end else if (regWrite) begin
            if (regAddr == REG_PIN_CONFIG) begin
                pinConfig <= regWdata;
            end
            if (regAddr == REG_BOOT_DEFINITION_TABLE_LOW) begin
                bootDefLow <= regWdata;
            end
        end
    end

    // writing bit 0 of control re-runs the decision, like a soft reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rebootReq <= 1'b0;
        end else begin
            rebootReq <= regWrite && (regAddr == REG_CONTROL) && regWdata[0];
        end
    end

    // ****************************************
    // decision
    // ****************************************
    bss_decode bss_decode_i (
        .pinConfig  (pinConfig),
        .bootDefLow (bootDefLow),
        .pinA       (syncA[1]),
        .pinB       (syncB[1]),
        .keyValid   (keyValid),
        .zeroPin    (zeroPin),
        .source     (next_source),
        .option     (next_option),
        .entry      (next_entry)
    );

    // ****************************************
    // boot sequence
    // ****************************************
    typedef enum logic [1:0] {
        BSS_ST_SYNC,
        BSS_ST_SETTLE,
        BSS_ST_SAMPLE,
        BSS_ST_DONE
    } bss_state_t;

    bss_state_t state;

    // two idle cycles let synchronised pins settle before they are sampled
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state  <= BSS_ST_SYNC;
            result <= '0;
        end else begin
            case (state)
                // reset clears both sync stages, so wait until the pin has reached stage two
                BSS_ST_SYNC: begin
                    state <= BSS_ST_SETTLE;
                end
                BSS_ST_SETTLE: begin
                    state <= BSS_ST_SAMPLE;
                end
                BSS_ST_SAMPLE: begin
                    state  <= BSS_ST_DONE;
                    result <= '{done: 1'b1, keyValid: keyValid, zeroPin: zeroPin,
                                source: next_source, option: next_option,
                                entry: next_entry};
                end
                BSS_ST_DONE: begin
                    if (rebootReq) begin
                        state       <= BSS_ST_SYNC;
                        result.done <= 1'b0;
                    end
                end
                default: begin
                    state <= BSS_ST_SYNC;
                end
            endcase
        end
    end

    assign bootDone   = result.done;
    assign bootSource = result.source;
    assign bootEntry  = result.entry;

    // ****************************************
    // read port
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= RESET_WORD;
        end else if (regRead) begin
            case (regAddr)
                REG_PIN_CONFIG:  regRdata <= pinConfig;
                REG_BOOT_DEFINITION_TABLE_LOW: regRdata <= bootDefLow;
                REG_STATUS:      regRdata <= {19'h0, result.option, result.source,
                                              result.zeroPin, result.keyValid, result.done};
                REG_ENTRY:       regRdata <= result.entry;
                default:         regRdata <= RESET_WORD;
            endcase
        end else begin
            regRdata <= RESET_WORD;
        end
    end

endmodule

// *** inc/bss_pkg.sv ***
package bss_pkg;

    // ****************************************
    // register map (byte addresses, 32-bit registers)
    // ****************************************
    localparam logic [11:0] REG_PIN_CONFIG   = 12'hD00;
    localparam logic [11:0] REG_BOOT_DEFINITION_TABLE_LOW  = 12'hD04;
    localparam logic [11:0] REG_CONTROL      = 12'hD10;
    localparam logic [11:0] REG_STATUS       = 12'hD14;
    localparam logic [11:0] REG_ENTRY        = 12'hD18;

    // ****************************************
    // field layout of the pin configuration word
    // ****************************************
    localparam int          KEY_LSB      = 24;
    localparam logic [7:0]  VALID_KEY    = 8'h5A;
    localparam int          PIN_A_LSB    = 0;
    localparam int          PIN_B_LSB    = 8;
    localparam logic [7:0]  PIN_DISABLED = 8'hFF;
    localparam int          ENTRY_WIDTH  = 8;

    // ****************************************
    // boot options and entry points
    // ****************************************
    localparam logic [7:0]  OPT_FLASH_ALT    = 8'h63;
    localparam logic [31:0] FLASH_ENTRY      = 32'h0008_0000;
    localparam logic [31:0] FLASH_ENTRY_ALT  = 32'h0009_0000;
    localparam logic [31:0] LOADER_ENTRY     = 32'h0000_0000;
    localparam logic [31:0] RESET_WORD       = 32'h0000_0000;

    typedef enum logic [1:0] {
        BSS_SRC_FLASH,
        BSS_SRC_FLASH_ALT,
        BSS_SRC_LOADER
    } bss_src_t;

    typedef struct packed {
        logic        done;
        logic        keyValid;
        logic        zeroPin;
        bss_src_t    source;
        logic [7:0]  option;
        logic [31:0] entry;
    } bss_result_t;

endpackage

// *** rtl/bss_decode.sv ***
`timescale 1ns/1ps
module bss_decode
    import bss_pkg::*;
(
    // configuration words
    input  wire logic [31:0] pinConfig,
    input  wire logic [31:0] bootDefLow,
    // sampled pins
    input  wire logic        pinA,
    input  wire logic        pinB,
    // decision
    output logic             keyValid,
    output logic             zeroPin,
    output bss_src_t         source,
    output logic [7:0]       option,
    output logic [31:0]      entry
);

    logic [7:0] pinAField;
    logic [7:0] pinBField;
    logic [1:0] index;
    logic [7:0] defEntry [4];

    // same field layout whether the words come from otp or emulation ram
    assign pinAField = pinConfig[PIN_A_LSB +: 8];
    assign pinBField = pinConfig[PIN_B_LSB +: 8];
    assign keyValid  = (pinConfig[KEY_LSB +: 8] == VALID_KEY);

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            defEntry[i] = bootDefLow[i*ENTRY_WIDTH +: ENTRY_WIDTH];
        end
        zeroPin = keyValid && (pinAField == PIN_DISABLED) && (pinBField == PIN_DISABLED);
        // a disabled pin reads as zero in the table index
        index   = {(pinBField != PIN_DISABLED) && pinB, (pinAField != PIN_DISABLED) && pinA};
        if (zeroPin) begin
            index = 2'h0;
        end
        option = 8'h00;
        source = BSS_SRC_LOADER;
        entry  = LOADER_ENTRY;
        if (!keyValid) begin
            // default pins: both high boots flash directly
            if (pinA && pinB) begin
                source = BSS_SRC_FLASH;
                entry  = FLASH_ENTRY;
            end
        end else begin
            option = defEntry[index];
            if (option == OPT_FLASH_ALT) begin
                source = BSS_SRC_FLASH_ALT;
                entry  = FLASH_ENTRY_ALT;
            end
        end
    end

endmodule

// *** tb/bss_boot_select_asserts.sv ***
`timescale 1ns/1ps
module bss_boot_select_asserts
    import bss_pkg::*;
(
    // watched ports
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [11:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regRdata,
    input wire logic        bootDone,
    input wire bss_src_t    bootSource,
    input wire logic [31:0] bootEntry
);
    // ****
    // properties
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire ctlWr = regWrite && regAddr == REG_CONTROL && regWdata[0];
    a_read_one_cycle: assert property (!$past(regRead) |-> regRdata == RESET_WORD)
        else $error("read data outside its cycle");
    a_entry_flash: assert property (bootDone && bootSource == BSS_SRC_FLASH
        |-> bootEntry == FLASH_ENTRY) else $error("flash entry wrong");
    a_entry_alt: assert property (bootDone && bootSource == BSS_SRC_FLASH_ALT
        |-> bootEntry == FLASH_ENTRY_ALT) else $error("alternate entry wrong");
    a_entry_loader: assert property (bootDone && bootSource == BSS_SRC_LOADER
        |-> bootEntry == LOADER_ENTRY) else $error("loader entry wrong");
    a_done_drop: assert property ($fell(bootDone) |-> $past(ctlWr, 2) || $past(ctlWr, 3))
        else $error("decision dropped without rerun");
    a_rerun_done: assert property (ctlWr |-> ##[2:3] !bootDone ##[1:3] bootDone)
        else $error("rerun did not complete");
    a_status_read: assert property (regRead && regAddr == REG_STATUS |=>
        regRdata[0] == $past(bootDone) && regRdata[4:3] == $past(bootSource))
        else $error("status read wrong");
    a_entry_read: assert property (regRead && regAddr == REG_ENTRY |=>
        regRdata == $past(bootEntry)) else $error("entry read wrong");
endmodule
bind bss_boot_select bss_boot_select_asserts chk_i (.clk(clk), .rstn(rstn),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .bootDone(bootDone), .bootSource(bootSource), .bootEntry(bootEntry));

// *** tb/bss_boot_select_tb_top.sv ***
`timescale 1ns/1ps
module bss_boot_select_tb_top
    import bss_pkg::*;
;
    logic        clk;
    logic        rstn = 1'b0;
    logic        pinA = 1'b1;
    logic        pinB = 1'b1;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [11:0] regAddr = 12'h000;
    logic [31:0] regWdata = 32'h0;
    logic [31:0] regRdata, bootEntry, cfg, def;
    logic        bootDone;
    bss_src_t    bootSource;
    int          failures = 0;
    int          samplesChecked = 0;
    int          cycles = 0;
    int          seed = 32'hA0A1;

    bss_boot_select bss_boot_select_i (.clk(clk), .rstn(rstn), .bootSelectPinA(pinA),
        .bootSelectPinB(pinB), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .bootDone(bootDone),
        .bootSource(bootSource), .bootEntry(bootEntry));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ****
    // checking
    // ****
    task check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [33:0] predict(input logic [31:0] c, d, input logic a, b);
        logic [1:0] idx;
        if (c[31:24] !== VALID_KEY)
            return (a && b) ? {BSS_SRC_FLASH, FLASH_ENTRY} : {BSS_SRC_LOADER, LOADER_ENTRY};
        idx = {c[15:8] != PIN_DISABLED && b, c[7:0] != PIN_DISABLED && a};
        return (d[idx*8 +: 8] == OPT_FLASH_ALT) ? {BSS_SRC_FLASH_ALT, FLASH_ENTRY_ALT}
                                                : {BSS_SRC_LOADER, LOADER_ENTRY};
    endfunction

    // status word: option, source, zero-pin, key valid, done
    function automatic logic [31:0] predictStatus(input logic [31:0] c, d, input logic a, b);
        logic        kv;
        logic [1:0]  idx;
        logic [33:0] p;
        kv  = (c[31:24] === VALID_KEY);
        idx = {c[15:8] != PIN_DISABLED && b, c[7:0] != PIN_DISABLED && a};
        p   = predict(c, d, a, b);
        return {19'h0, kv ? d[idx*8 +: 8] : 8'h00, p[33:32],
                kv && c[15:0] == {PIN_DISABLED, PIN_DISABLED}, kv, 1'b1};
    endfunction

    task print_verdict();
        $display("checks %0d failures %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            failures++;
            print_verdict();
        end
    end

    // ****
    // bus and boot tasks
    // ****
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask

    task rdc(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 check("read", {2'h0, regRdata}, {2'h0, e});
    endtask

    // bounded wait so a stuck decision cannot hang the run
    task waitDone();
        for (int i = 0; i < 12 && bootDone !== 1'b1; i++)
            @(posedge clk);
        #1;
    endtask

    task boot(input logic [31:0] c, d, input logic a, b);
        logic [33:0] want;
        want = predict(c, d, a, b);
        wr(REG_PIN_CONFIG, c);
        wr(REG_BOOT_DEFINITION_TABLE_LOW, d);
        rdc(REG_PIN_CONFIG, c);
        rdc(REG_BOOT_DEFINITION_TABLE_LOW, d);
        pinA <= a;
        pinB <= b;
        repeat (4) @(posedge clk);
        wr(REG_CONTROL, 32'h0000_0001);
        repeat (3) @(posedge clk);
        waitDone();
        check("boot", {bootSource, bootEntry}, want);
        rdc(REG_ENTRY, want[31:0]);
        rdc(REG_STATUS, predictStatus(c, d, a, b));
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        waitDone();
        check("default", {bootSource, bootEntry}, {BSS_SRC_FLASH, FLASH_ENTRY});
        rdc(12'hD20, 32'h0);
        boot(32'h5AFF_FFFF, 32'h0000_0063, 1'b0, 1'b1);
        boot(32'h5AFF_FFFF, 32'h6363_6300, 1'b1, 1'b1);
        boot(32'hA5FF_FFFF, 32'h0000_0063, 1'b1, 1'b1);
        boot(32'h5A00_0000, 32'h6300_0000, 1'b1, 1'b1);
        for (int i = 0; i < 24; i++) begin
            cfg = $random(seed);
            def = $random(seed);
            if (cfg[0])
                cfg[31:24] = VALID_KEY;
            if (cfg[2])
                cfg[7:0] = PIN_DISABLED;
            if (cfg[9])
                cfg[15:8] = PIN_DISABLED;
            if (def[3])
                def[7:0] = OPT_FLASH_ALT;
            boot(cfg, def, def[30], def[31]);
        end
        // mid-run reset clears the words, so the default pin boot returns
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        waitDone();
        check("reset boot", {bootSource, bootEntry}, predict(RESET_WORD, RESET_WORD, pinA, pinB));
        rdc(REG_PIN_CONFIG, RESET_WORD);
        print_verdict();
    end
endmodule
